/* ssrc_pkg.sv */
package ssrc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned NS_PER_S = 1000000000;
  localparam int unsigned CYCLES_PER_SEC = NS_PER_S / CLK_PERIOD_NS;
  localparam int unsigned SEARCH_TIME_S = 30;
  localparam int unsigned CHECK_TIME_MIN = 30;
  localparam int unsigned CHECK_TIME_S = CHECK_TIME_MIN * 60;
  localparam int unsigned SEC_W = 12;

  localparam int unsigned AW = 4;
  localparam logic [AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AW-1:0] REG_EXT_ADDR = 4'h1;
  localparam logic [AW-1:0] REG_SRC_MAP = 4'h2;
  localparam logic [AW-1:0] REG_PRI_SRC = 4'h3;
  localparam logic [AW-1:0] REG_RSSI_THR = 4'h4;
  localparam logic [AW-1:0] REG_ARQ = 4'h5;
  localparam logic [AW-1:0] REG_STATUS = 4'h6;
  localparam logic [AW-1:0] REG_INT_STAT = 4'h7;
  localparam logic [AW-1:0] REG_INT_MASK = 4'h8;

  localparam int unsigned CTRL_SF_BIT = 2;
  localparam int unsigned PRI_NONE_BIT = 5;
  localparam int unsigned THR_SET_BIT = 8;
  localparam int unsigned ARQ_RETRY_LSB = 8;
  localparam int unsigned ST_LOCK_BIT = 0;
  localparam int unsigned ST_SRC_LSB = 1;
  localparam int unsigned ST_TDD_BIT = 6;
  localparam int unsigned ST_SLOT_BIT = 7;
  localparam int unsigned ST_PERS_BIT = 8;
  localparam int unsigned ST_BUSY_BIT = 9;

  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_ACQ = 0;
  localparam int unsigned IRQ_LOST = 1;
  localparam int unsigned IRQ_FALLBACK = 2;
  localparam int unsigned IRQ_DISCARD = 3;
  localparam int unsigned IRQ_EXHAUST = 4;

  typedef enum logic [1:0] {
    ROLE_REMOTE = 2'h0,
    ROLE_EXT = 2'h1,
    ROLE_MASTER = 2'h2
  } ssrc_role_t;

  typedef enum logic [2:0] {
    SY_HUNT_PRI = 3'h1,
    SY_HUNT_ANY = 3'h2,
    SY_LOCKED = 3'h4
  } ssrc_sync_t;

  typedef struct packed {
    logic syncValid;
    logic [4:0] addr;
    logic fromMaster;
    logic fromExt;
    logic [7:0] rssi;
  } ssrc_rx_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ssrc_bus_t;

  typedef struct packed {
    logic [31:0] div;
    logic [SEC_W-1:0] secs;
    logic [SEC_W-1:0] chk;
    logic searchDone;
    logic checkDue;
  } ssrc_tmr_t;

  typedef struct packed {
    logic busy;
    logic first;
    logic mstr;
    logic [4:0] src;
    logic [4:0] left;
    logic txReq;
    logic discard;
    logic exhausted;
  } ssrc_retx_t;
endpackage

/* ssrc_sync_timer.sv */
`timescale 1ns/100ps
module ssrc_sync_timer import ssrc_pkg::*; #(
  parameter int unsigned SEC_CYCLES = CYCLES_PER_SEC
) (
  input logic mclk,
  input logic sys_rst,
  input logic restart,
  input logic run,
  output logic searchDone,
  output logic checkDue
);
  ssrc_tmr_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.searchDone = 1'b0;
    s_next.checkDue = 1'b0;
    if (restart) begin
      s_next.div = '0;
      s_next.secs = '0;
      s_next.chk = '0;
    end else if (s_reg.div == 32'(SEC_CYCLES - 1)) begin
      s_next.div = '0;
      if (s_reg.secs != SEC_W'(SEARCH_TIME_S)) begin
        s_next.secs = s_reg.secs + 1'b1;
        s_next.searchDone = run && (s_reg.secs == SEC_W'(SEARCH_TIME_S - 1));
      end
      if (s_reg.chk == SEC_W'(CHECK_TIME_S - 1)) begin
        s_next.chk = '0;
        s_next.checkDue = run;
      end else begin
        s_next.chk = s_reg.chk + 1'b1;
      end
    end else begin
      s_next.div = s_reg.div + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign searchDone = s_reg.searchDone;
  assign checkDue = s_reg.checkDue;

  search_after_30s_a: assert property (@(posedge mclk) disable iff (sys_rst)
    searchDone |-> s_reg.secs == SEC_W'(SEARCH_TIME_S))
    else $error("search timeout at wrong second count");
  check_restart_a: assert property (@(posedge mclk) disable iff (sys_rst)
    restart |=> s_reg.secs == '0 && s_reg.chk == '0 && !checkDue)
    else $error("timers did not restart");
endmodule

/* ssrc_retx.sv */
`timescale 1ns/100ps
module ssrc_retx import ssrc_pkg::*; (
  input logic mclk,
  input logic sys_rst,
  input logic msgValid,
  input logic [4:0] msgSrc,
  input logic masterPers,
  input logic [3:0] repeatN,
  input logic [3:0] retryN,
  input logic ackRx,
  input logic txOpp,
  output logic txReq,
  output logic discard,
  output logic exhausted,
  output logic busy
);
  ssrc_retx_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.txReq = 1'b0;
    s_next.discard = 1'b0;
    s_next.exhausted = 1'b0;
    if (msgValid) begin
      s_next.discard = s_reg.busy && (msgSrc != s_reg.src);
      s_next.busy = 1'b1;
      s_next.first = 1'b1;
      s_next.mstr = masterPers;
      s_next.src = msgSrc;
      s_next.left = masterPers ? {1'b0, repeatN} : {1'b0, retryN};
    end else if (ackRx && s_reg.busy && !s_reg.mstr && !s_reg.first) begin
      s_next.busy = 1'b0;
    end else if (txOpp && s_reg.busy) begin
      if (s_reg.first) begin
        s_next.first = 1'b0;
        s_next.txReq = 1'b1;
      end else if (s_reg.left != '0) begin
        s_next.left = s_reg.left - 1'b1;
        s_next.txReq = 1'b1;
      end else begin
        s_next.busy = 1'b0;
        s_next.exhausted = !s_reg.mstr;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign txReq = s_reg.txReq;
  assign discard = s_reg.discard;
  assign exhausted = s_reg.exhausted;
  assign busy = s_reg.busy;

  master_ignores_ack_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.busy && s_reg.mstr && ackRx && !msgValid && !txOpp |=> s_reg.busy)
    else $error("master role stopped repeats on ack");
  new_source_wins_a: assert property (@(posedge mclk) disable iff (sys_rst)
    msgValid && s_reg.busy && msgSrc != s_reg.src |=> discard && s_reg.first && s_reg.src == $past(msgSrc))
    else $error("new source did not preempt old data");
endmodule

/* ssrc_top.sv */
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
module ssrc_top import ssrc_pkg::*; #(
  parameter int unsigned SEC_CYCLES = CYCLES_PER_SEC
) (
  input logic mclk,
  input logic sys_rst,
  input ssrc_bus_t bus,
  output logic [31:0] rdata,
  output logic irq,
  input ssrc_rx_t rx,
  input logic rxSyncLost,
  input logic rxTddCmd,
  input logic slotTick,
  input logic rxAck,
  input logic rxDataValid,
  input logic [4:0] rxDataSrc,
  output logic txSyncEn,
  output logic tddCmdTx,
  output logic tddActive,
  output logic slotUp,
  output logic persMaster,
  output logic synced,
  output logic [4:0] syncSrc,
  output logic retxReq
);
  typedef struct packed {
    ssrc_role_t role;
    logic sfEn;
    logic [4:0] extAddr;
    logic [31:0] srcMap;
    logic [5:0] priSrc;
    logic [8:0] rssiThr;
    logic [3:0] repeatN;
    logic [3:0] retryN;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic [31:0] rdata;
    logic irq;
    ssrc_sync_t sync;
    logic [4:0] src;
    logic [7:0] rssi;
    logic tdd;
    logic slotUp;
    logic persMaster;
    logic txSync;
    logic tddCmdTx;
    logic tmrRestart;
    logic synced;
  } ssrc_top_t;

  ssrc_top_t s_reg, s_next;
  logic searchDone, checkDue;
  logic retxTx, retxDiscard, retxExhaust, retxBusy;
  logic priDef, thrSet, senderOk, addrOk, accept, weakSrc;
  logic [IRQ_W-1:0] evt;

  ssrc_sync_timer #(.SEC_CYCLES(SEC_CYCLES)) u_tmr (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .restart(s_reg.tmrRestart),
    .run(priDef && s_reg.role != ROLE_MASTER),
    .searchDone(searchDone),
    .checkDue(checkDue)
  );

  ssrc_retx u_retx (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .msgValid(rxDataValid),
    .msgSrc(rxDataSrc),
    .masterPers(s_reg.persMaster),
    .repeatN(s_reg.repeatN),
    .retryN(s_reg.retryN),
    .ackRx(rxAck),
    .txOpp(slotTick),
    .txReq(retxTx),
    .discard(retxDiscard),
    .exhausted(retxExhaust),
    .busy(retxBusy)
  );

  always_comb begin
    priDef = !s_reg.priSrc[PRI_NONE_BIT];
    thrSet = s_reg.rssiThr[THR_SET_BIT];
    senderOk = rx.fromMaster || rx.fromExt;
    // Only the primary is heard while hunting for it
    if (s_reg.sync == SY_HUNT_PRI) begin
      addrOk = priDef ? (rx.addr == s_reg.priSrc[4:0]) : s_reg.srcMap[rx.addr];
    end else begin
      addrOk = (priDef && rx.addr == s_reg.priSrc[4:0]) || s_reg.srcMap[rx.addr];
    end
    accept = rx.syncValid && senderOk && addrOk && s_reg.role != ROLE_MASTER
      && !s_reg.persMaster;
    weakSrc = s_reg.src != s_reg.priSrc[4:0]
      && (!thrSet || s_reg.rssi < s_reg.rssiThr[7:0]);
  end

  always_comb begin
    s_next = s_reg;
    evt = '0;
    s_next.tddCmdTx = 1'b0;
    s_next.tmrRestart = 1'b0;
    s_next.rdata = '0;

    // Register writes
    if (bus.wr) begin
      unique case (bus.addr)
        REG_CTRL: begin
          s_next.role = ssrc_role_t'(bus.wdata[1:0]);
          s_next.sfEn = bus.wdata[CTRL_SF_BIT];
        end
        REG_EXT_ADDR: s_next.extAddr = bus.wdata[4:0];
        REG_SRC_MAP: s_next.srcMap = bus.wdata;
        REG_PRI_SRC: s_next.priSrc = bus.wdata[5:0];
        REG_RSSI_THR: s_next.rssiThr = bus.wdata[8:0];
        REG_ARQ: begin
          s_next.repeatN = bus.wdata[3:0];
          s_next.retryN = bus.wdata[ARQ_RETRY_LSB +: 4];
        end
        REG_INT_MASK: s_next.irqMask = bus.wdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // Master broadcasts the TDD command on enable
    if (s_reg.role == ROLE_MASTER) begin
      if (s_next.sfEn && !s_reg.sfEn) begin
        s_next.tddCmdTx = 1'b1;
      end
      s_next.tdd = s_next.sfEn;
    end else if (rxTddCmd && s_reg.sync == SY_LOCKED && senderOk) begin
      s_next.tdd = 1'b1;
    end

    if (slotTick && s_reg.tdd) begin
      s_next.slotUp = !s_reg.slotUp;
    end else if (!s_reg.tdd) begin
      s_next.slotUp = 1'b1;
    end

    // Sync source selection
    if (s_reg.role == ROLE_MASTER) begin
      s_next.sync = SY_LOCKED;
    end else begin
      unique case (s_reg.sync)
        SY_HUNT_PRI: begin
          if (accept) begin
            s_next.sync = SY_LOCKED;
            s_next.src = rx.addr;
            s_next.rssi = rx.rssi;
            evt[IRQ_ACQ] = 1'b1;
          end else if (searchDone || !priDef) begin
            s_next.sync = SY_HUNT_ANY;
            evt[IRQ_FALLBACK] = priDef;
          end
        end
        SY_HUNT_ANY: begin
          if (accept) begin
            s_next.sync = SY_LOCKED;
            s_next.src = rx.addr;
            s_next.rssi = rx.rssi;
            evt[IRQ_ACQ] = 1'b1;
          end
        end
        SY_LOCKED: begin
          if (rx.syncValid && senderOk && rx.addr == s_reg.src) begin
            s_next.rssi = rx.rssi;
          end
          if (rxSyncLost || (checkDue && priDef && weakSrc)) begin
            s_next.sync = SY_HUNT_PRI;
            s_next.tmrRestart = 1'b1;
            s_next.tdd = 1'b0;
            evt[IRQ_LOST] = 1'b1;
          end
        end
      endcase
    end

    if (s_reg.role == ROLE_MASTER) begin
      s_next.persMaster = 1'b1;
      s_next.txSync = 1'b1;
    end else if (s_reg.role == ROLE_EXT) begin
      s_next.persMaster = s_next.tdd && !s_next.slotUp;
      s_next.txSync = s_next.sync == SY_LOCKED
        && (!s_next.tdd || s_next.persMaster);
    end else begin
      s_next.persMaster = 1'b0;
      s_next.txSync = 1'b0;
    end

    // Lock flag kept in a flop for the pin
    s_next.synced = s_next.sync == SY_LOCKED;

    evt[IRQ_DISCARD] = retxDiscard;
    evt[IRQ_EXHAUST] = retxExhaust;
    // Set wins over the write-one clear
    if (bus.wr && bus.addr == REG_INT_STAT) begin
      s_next.irqStat = (s_reg.irqStat & ~bus.wdata[IRQ_W-1:0]) | evt;
    end else begin
      s_next.irqStat = s_reg.irqStat | evt;
    end
    s_next.irq = |(s_next.irqStat & s_next.irqMask);

    if (bus.rd) begin
      unique case (bus.addr)
        REG_CTRL: s_next.rdata = {29'h0, s_reg.sfEn, s_reg.role};
        REG_EXT_ADDR: s_next.rdata = {27'h0, s_reg.extAddr};
        REG_SRC_MAP: s_next.rdata = s_reg.srcMap;
        REG_PRI_SRC: s_next.rdata = {26'h0, s_reg.priSrc};
        REG_RSSI_THR: s_next.rdata = {23'h0, s_reg.rssiThr};
        REG_ARQ: s_next.rdata = {20'h0, s_reg.retryN, 4'h0, s_reg.repeatN};
        REG_STATUS: begin
          s_next.rdata[ST_LOCK_BIT] = s_reg.sync == SY_LOCKED;
          s_next.rdata[ST_SRC_LSB +: 5] = s_reg.src;
          s_next.rdata[ST_TDD_BIT] = s_reg.tdd;
          s_next.rdata[ST_SLOT_BIT] = s_reg.slotUp;
          s_next.rdata[ST_PERS_BIT] = s_reg.persMaster;
          s_next.rdata[ST_BUSY_BIT] = retxBusy;
        end
        REG_INT_STAT: s_next.rdata = {27'h0, s_reg.irqStat};
        REG_INT_MASK: s_next.rdata = {27'h0, s_reg.irqMask};
        default: s_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.sync <= SY_HUNT_PRI;
      s_reg.slotUp <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign irq = s_reg.irq;
  assign txSyncEn = s_reg.txSync;
  assign tddCmdTx = s_reg.tddCmdTx;
  assign tddActive = s_reg.tdd;
  assign slotUp = s_reg.slotUp;
  assign persMaster = s_reg.persMaster;
  assign synced = s_reg.synced;
  assign syncSrc = s_reg.src;
  assign retxReq = retxTx;

  master_sync_tx_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.role == ROLE_MASTER && $stable(s_reg.role) |-> txSyncEn)
    else $error("master not sending sync");
  ext_wait_lock_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.role == ROLE_EXT && txSyncEn |-> synced)
    else $error("extension sent sync while unlocked");
  valid_sender_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.role != ROLE_MASTER && $rose(synced) |-> $past(rx.fromMaster || rx.fromExt))
    else $error("locked to an invalid sender");
  tdd_broadcast_a: assert property (@(posedge mclk) disable iff (sys_rst)
    tddCmdTx |-> tddActive && s_reg.role == ROLE_MASTER)
    else $error("command broadcast without TDD");
  slot_alternate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    tddActive && slotTick ##1 tddActive |-> slotUp != $past(slotUp))
    else $error("slot did not alternate");
  source_map_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.sync == SY_HUNT_ANY ##1 synced |-> s_reg.srcMap[syncSrc]
      || (!s_reg.priSrc[PRI_NONE_BIT] && syncSrc == s_reg.priSrc[4:0]))
    else $error("locked to source outside map");
  weak_force_loss_a: assert property (@(posedge mclk) disable iff (sys_rst)
    synced && s_reg.role != ROLE_MASTER && checkDue && priDef && weakSrc
      |=> s_reg.sync == SY_HUNT_PRI ##1 s_reg.irqStat[IRQ_LOST])
    else $error("weak source not dropped");
  reset_defaults_a: assert property (@(posedge mclk)
    $past(sys_rst) |-> s_reg.extAddr == '0 && s_reg.srcMap == '0 && s_reg.priSrc == '0 && !thrSet)
    else $error("reset defaults wrong");

  // Role, hunt order and loss handling
  master_locked_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.role == ROLE_MASTER && $stable(s_reg.role) |-> synced)
    else $error("master role not locked");
  tdd_needs_lock_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.role != ROLE_MASTER && !synced && !tddActive |=> !tddActive)
    else $error("TDD entered while unlocked");
  ext_slot_split_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.role == ROLE_EXT && $stable(s_reg.role) && tddActive |-> persMaster == !slotUp)
    else $error("extension personality not tied to slot");
  ext_tx_own_slot_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.role == ROLE_EXT && $stable(s_reg.role) && tddActive && txSyncEn |-> persMaster)
    else $error("extension sent sync in remote slot");
  primary_first_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.role != ROLE_MASTER && s_reg.sync == SY_HUNT_PRI && !s_reg.priSrc[PRI_NONE_BIT]
      ##1 synced |-> syncSrc == $past(s_reg.priSrc[4:0]))
    else $error("locked to non-primary during primary hunt");
  fallback_late_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(s_reg.sync == SY_HUNT_ANY) && !$past(s_reg.priSrc[PRI_NONE_BIT]) |-> $past(searchDone))
    else $error("fallback before search timeout");
  loss_restarts_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.role != ROLE_MASTER && synced && rxSyncLost |=> !synced && s_reg.tmrRestart)
    else $error("sync loss did not restart timers");

  // Interrupt pin and read data framing
  irq_level_a: assert property (@(posedge mclk) disable iff (sys_rst)
    irq == |(s_reg.irqStat & s_reg.irqMask))
    else $error("interrupt pin disagrees with status");
  rdata_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !$past(bus.rd) |-> rdata == '0)
    else $error("read data not zero outside read");
endmodule

/* ssrc_peer_model.sv */
`timescale 1ns/100ps
module ssrc_peer_model import ssrc_pkg::*; (
  input logic mclk,
  output ssrc_rx_t rx,
  output logic rxTddCmd,
  output logic rxAck,
  output logic slotTick
);
  initial begin
    rx = '0;
    rxTddCmd = 1'b0;
    rxAck = 1'b0;
    slotTick = 1'b0;
  end
  // One sync message; once released, the flags clear and the address and RSSI are inverted
  task automatic sync(input logic [4:0] a, input logic m, input logic x,
                      input logic [7:0] r);
    @(posedge mclk);
    rx <= '{1'b1, a, m, x, r};
    @(posedge mclk);
    rx <= '{1'b0, ~a, 1'b0, 1'b0, ~r};
  endtask
  task automatic tddCmd();
    @(posedge mclk);
    rxTddCmd <= 1'b1;
    @(posedge mclk);
    rxTddCmd <= 1'b0;
  endtask
  // Only the polled unit answers, after d+1 cycles
  task automatic ack(input int d);
    repeat (d) @(posedge mclk);
    @(posedge mclk);
    rxAck <= 1'b1;
    @(posedge mclk);
    rxAck <= 1'b0;
  endtask
  task automatic tick();
    @(posedge mclk);
    slotTick <= 1'b1;
    @(posedge mclk);
    slotTick <= 1'b0;
  endtask
endmodule

/* ssrc_tb.sv */
`timescale 1ns/100ps
module tb import ssrc_pkg::*;;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  ssrc_bus_t bus = '0;
  logic rxSyncLost = 1'b0;
  logic rxDataValid = 1'b0;
  logic [4:0] rxDataSrc = 5'h0;
  logic [31:0] rdata;
  logic irq, txSyncEn, tddCmdTx, tddActive, slotUp, persMaster, synced, retxReq;
  logic [4:0] syncSrc;
  ssrc_rx_t rx;
  logic rxTddCmd, rxAck, slotTick;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int tot = 0;
  int nRetx = 0;
  int nCmd = 0;
  int k;
  logic [31:0] expQ[$];
  logic rdV = 1'b0;
  logic e;
  logic [7:0] rs;

  ssrc_top #(.SEC_CYCLES(2)) dut (.mclk(mclk), .sys_rst(sys_rst), .bus(bus),
    .rdata(rdata), .irq(irq), .rx(rx), .rxSyncLost(rxSyncLost), .rxTddCmd(rxTddCmd),
    .slotTick(slotTick), .rxAck(rxAck), .rxDataValid(rxDataValid),
    .rxDataSrc(rxDataSrc), .txSyncEn(txSyncEn), .tddCmdTx(tddCmdTx),
    .tddActive(tddActive), .slotUp(slotUp), .persMaster(persMaster),
    .synced(synced), .syncSrc(syncSrc), .retxReq(retxReq));
  ssrc_peer_model peer (.mclk(mclk), .rx(rx), .rxTddCmd(rxTddCmd), .rxAck(rxAck),
    .slotTick(slotTick));

  always #2.5 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus <= '{a, d, 1'b0, 1'b0};
  endtask
  // Notes the expected word, the watcher compares it
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    expQ.push_back(x);
    @(posedge mclk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk);
    bus <= '{a, 32'h0, 1'b0, 1'b0};
  endtask
  task automatic rst();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic dat(input logic [4:0] s);
    @(posedge mclk);
    rxDataValid <= 1'b1;
    rxDataSrc <= s;
    @(posedge mclk);
    rxDataValid <= 1'b0;
    rxDataSrc <= ~s;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      peer.tick();
      @(posedge mclk);
    end
  endtask

  always @(posedge mclk) begin
    cyc <= sys_rst ? 0 : cyc + 1;
    tot <= tot + 1;
    nRetx <= nRetx + int'(retxReq);
    nCmd <= nCmd + int'(tddCmdTx);
    rdV <= bus.rd;
    if (rdV) begin
      chk(rdata, expQ.pop_front());
    end
    if (tot == 8000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    void'($urandom(43486));
    rst();
    rd(REG_EXT_ADDR, 32'h0);
    rd(REG_SRC_MAP, 32'h0);
    rd(REG_PRI_SRC, 32'h0);
    rd(REG_RSSI_THR, 32'h0);
    rd(REG_STATUS, 32'h80);
    rd(4'hf, 32'h0);
    wr(REG_SRC_MAP, 32'h8);
    peer.sync(5'h3, 1'b1, 1'b0, 8'h40);
    settle(2);
    chk(synced, 1'b0);
    while (cyc < 70) @(posedge mclk);
    peer.sync(5'h3, 1'b0, 1'b0, 8'h40);
    settle(2);
    chk(synced, 1'b0);
    rs = 8'($urandom());
    peer.sync(5'h3, 1'b0, 1'b1, rs);
    settle(2);
    chk({syncSrc, synced}, 6'h07);
    rd(REG_INT_STAT, 32'h5);
    settle(2);
    chk(irq, 1'b0);
    wr(REG_INT_MASK, 32'h4);
    settle(2);
    chk(irq, 1'b1);
    wr(REG_INT_STAT, 32'h5);
    settle(2);
    chk(irq, 1'b0);
    while (cyc < 3500) @(posedge mclk);
    settle(0);
    chk(synced, 1'b1);
    for (int i = 0; i < 200 && synced !== 1'b0; i++) @(posedge mclk);
    chk(cyc >= 3595 && cyc <= 3612, 1'b1);
    rd(REG_INT_STAT, 32'h2);
    peer.sync(5'h3, 1'b0, 1'b1, rs);
    settle(2);
    chk(synced, 1'b0);
    // Master role
    rst();
    wr(REG_CTRL, 32'h2);
    settle(2);
    chk({txSyncEn, synced}, 2'h3);
    k = nCmd;
    wr(REG_CTRL, 32'h6);
    settle(3);
    chk(nCmd - k, 32'h1);
    chk(tddActive, 1'b1);
    // Extension role
    rst();
    wr(REG_CTRL, 32'h1);
    settle(2);
    chk(txSyncEn, 1'b0);
    peer.sync(5'h0, 1'b1, 1'b0, 8'($urandom()));
    settle(2);
    chk({txSyncEn, synced}, 2'h3);
    fork
      peer.sync(5'h0, 1'b1, 1'b0, rs);
      peer.tddCmd();
    join
    settle(2);
    chk({tddActive, slotUp}, 2'h3);
    e = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ticks(1);
      #1;
      e = ~e;
      chk({slotUp, persMaster, txSyncEn}, {e, ~e, ~e});
    end
    wr(REG_ARQ, 32'h102);
    wr(REG_INT_STAT, 32'h1f);
    k = nRetx;
    dat(5'h9);
    ticks(4);
    chk(nRetx - k, 32'h2);
    rd(REG_INT_STAT, 32'h10);
    wr(REG_INT_STAT, 32'h1f);
    k = nRetx;
    dat(rs[4:0]);
    ticks(1);
    peer.ack(2);
    ticks(3);
    chk(nRetx - k, 32'h1);
    rd(REG_INT_STAT, 32'h0);
    ticks(1);
    k = nRetx;
    dat(5'h4);
    ticks(1);
    peer.ack(0);
    ticks(4);
    chk(nRetx - k, 32'h3);
    dat(5'h5);
    ticks(1);
    dat(5'h6);
    settle(2);
    rd(REG_INT_STAT, 32'h8);
    @(posedge mclk);
    rxSyncLost <= 1'b1;
    @(posedge mclk);
    rxSyncLost <= 1'b0;
    settle(2);
    chk({synced, tddActive, txSyncEn}, 3'h0);
    rd(REG_INT_STAT, 32'ha);
    settle(2);
    results();
  end
endmodule
